//--- hw/dwrd_pkg.sv
// Package for the DMA write register decoder: byte classes, field positions,
// sequencer states and reset values.
// Assumes a single 25 MHz system clock domain.
package dwrd_pkg;

    // Basic byte bit positions
    localparam int B_TOP = 7;
    localparam int B_P6 = 6;
    localparam int B_P5 = 5;
    localparam int B_P4 = 4;
    localparam int B_P3 = 3;
    localparam int B_P2 = 2;
    localparam int B_P1 = 1;
    localparam int B_P0 = 0;

    // Field widths and reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [1:0] TWO_ZERO = 2'h0;
    localparam logic [1:0] CLASS_SEARCH = 2'h2;
    localparam logic [1:0] CYC_STD = 2'h0;
    localparam logic [16:0] LEN_ZERO_COUNT = 17'h10001;
    localparam logic [16:0] LEN_ADD = 17'h00001;
    localparam logic [1:0] CAUSE_MATCH = 2'h1;
    localparam logic [1:0] CAUSE_END = 2'h2;
    localparam logic [1:0] CAUSE_READY = 2'h0;

    // Pending related-byte slots, expanded in ascending order
    localparam int SLOT_N = 5;
    localparam logic [SLOT_N-1:0] SLOTS_NONE = 5'h00;

    typedef enum logic [6:0] {
        SEQ_BASIC = 7'h01,
        SEQ_XFER = 7'h02,
        SEQ_PORTA = 7'h04,
        SEQ_PORTB = 7'h08,
        SEQ_MATCH = 7'h10,
        SEQ_MODE = 7'h20,
        SEQ_INTCTL = 7'h40
    } dwrd_seq_type;

endpackage

//--- hw/dwrd_sync.sv
// Two-stage synchroniser for one level signal.
// Assumes the destination clock is the block's system clock.
`timescale 1ns/1ps
module dwrd_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic [1:0] stage_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_ff <= {RST_VAL, RST_VAL};
        end else if (ce) begin
            stage_ff <= {stage_ff[0], d};
        end
    end

    assign q = stage_ff[1];
endmodule // dwrd_sync

//--- hw/dwrd_decoder.sv
// Write register decoder for transfer setup, port setup, match control and
// mode/interrupt groups of a byte-serial DMA programming port.
// Assumes the host write strobe, chip select and data come from pins,
// and the byte counter and transfer data come from on-chip transfer logic.
//
// Contract
// - Bit7 clear with bits 1:0 nonzero selects transfer setup group.
// - Each set pointer bit pulls the next written byte into its register.
// - Transfer setup bits 1:0 give the operating class.
// - Transfer setup bit 2 picks source port; other port is destination.
// - Bits 3,4 flag port A address bytes; bits 5,6 flag length bytes.
// - Block length 16 bits; zero length means 2^16+1 bytes.
// - Bits 0,1,7 clear and bit 2 set selects port A setup group.
// - Port setup bit 3 chooses memory or I/O strobe for that port.
// - Bits 4,5 address stepping; bit 6 flags a timing byte.
// - Timing byte bits 1:0 cycle length; bits 2,3,6,7 early strobe ends.
// - Bits 0,1,2,7 clear selects port B setup group, same layout.
// - Bits 0,1 clear and bit 7 set selects match control group.
// - Stop-on-match halts on a match; otherwise flag and interrupt only.
// - Match control bit 3 flags mask byte, bit 4 match byte, in order.
// - Mask bits at one exclude positions; zero mask compares all bits.
// - Match control bit 5 enables interrupts, bit 6 enables bus requests.
// - Bits 0,7 set and bit 1 clear selects mode/interrupt group.
// - Mode bits 2-4 flag port B low, high and interrupt control bytes.
// - Mode bits 5,6 select byte, burst or continuous operation.
// - Interrupt control bits: on match, on end of block, pulse enable.
// - Bit 3 flags pulse byte, bit 4 vector; bit 5 status vector.
// - Interrupt-on-ready interrupts before bus request; host re-enables.
// - Pulse on interrupt line when pulse byte equals counter low byte.
// - Bits 1,7 set, bits 0,2,6 clear selects ready polarity group.
// - Bits 0,1,7 set is a command byte, not stored in setup groups.
// - Status vector replaces vector bits 2:1 with the cause code.
`timescale 1ns/1ps
module dwrd_decoder (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic HOST_WR_N,
    input wire logic HOST_CS_N,
    input wire logic [7:0] HOST_DATA,
    input wire logic [15:0] BYTE_COUNT,
    input wire logic [7:0] XFER_DATA,
    input wire logic XFER_DATA_VALID,
    input wire logic READY_SEEN,
    input wire logic BLOCK_END,
    input wire logic REENABLE,
    output logic [1:0] OP_CLASS,
    output logic SRC_IS_A,
    output logic [15:0] PORT_A_START,
    output logic [15:0] PORT_B_START,
    output logic [16:0] BYTES_TO_DO,
    output logic [1:0] PORT_A_ADDR_MODE,
    output logic [1:0] PORT_B_ADDR_MODE,
    output logic PORT_A_IS_IO,
    output logic PORT_B_IS_IO,
    output logic PORT_A_VAR_TIMING,
    output logic PORT_B_VAR_TIMING,
    output logic [7:0] PORT_A_TIMING,
    output logic [7:0] PORT_B_TIMING,
    output logic [1:0] OP_MODE,
    output logic BUS_ENABLE,
    output logic STOP_ON_MATCH,
    output logic MATCH_HIT,
    output logic MATCH_STOP,
    output logic MATCH_FLAG,
    output logic INT_REQ,
    output logic PULSE_OUT,
    output logic [7:0] INT_VECTOR,
    output logic READY_POL_WR,
    output logic [7:0] READY_POL_BYTE,
    output logic CMD_VALID,
    output logic [7:0] CMD_BYTE
);
    import dwrd_pkg::*;

    typedef struct packed {
        logic wr_d;
        dwrd_seq_type seq;
        logic [SLOT_N-1:0] pend;
        logic [1:0] op_class;
        logic src_a;
        logic [15:0] a_start;
        logic [15:0] b_start;
        logic [15:0] length;
        logic [16:0] bytes_to_do;
        logic [2:0] a_setup;
        logic [2:0] b_setup;
        logic a_var;
        logic b_var;
        logic [7:0] a_timing;
        logic [7:0] b_timing;
        logic stop_match;
        logic int_en;
        logic bus_en;
        logic [7:0] mask;
        logic [7:0] match_val;
        logic [1:0] op_mode;
        logic [7:0] int_ctl;
        logic [7:0] pulse_off;
        logic [7:0] vector;
        logic match_hit;
        logic match_stop;
        logic match_flag;
        logic int_req;
        logic pulse;
        logic [7:0] vec_out;
        logic rp_wr;
        logic [7:0] rp_byte;
        logic cmd_valid;
        logic [7:0] cmd_byte;
    } dwrd_state_type;

    dwrd_state_type st_ff;
    dwrd_state_type nxt_st;
    logic wr_n_s;
    logic cs_n_s;
    logic [1:0] rst_sync_ff;
    logic [7:0] data_q;
    logic rst_core_n;
    // All state clears to zero except the sequencer and the length count
    localparam dwrd_state_type ST_RESET = '{seq: SEQ_BASIC,
        pend: SLOTS_NONE, bytes_to_do: LEN_ZERO_COUNT, default: '0};

    // Reset release passes two flops so every state flop sees a clean edge;
    // kept apart from the state struct since it runs on the raw pin reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_ff[1];

    // Host strobes arrive from pins and are synchronised before decoding
    dwrd_sync #(.RST_VAL(1'b1)) u_sync_wr (
        .clk(CLK), .rst_n(rst_core_n), .ce(CE), .d(HOST_WR_N), .q(wr_n_s)
    );
    dwrd_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .clk(CLK), .rst_n(rst_core_n), .ce(CE), .d(HOST_CS_N), .q(cs_n_s)
    );

    // Data lines: one synchroniser per bit; the byte taken is sampled as the strobe rises
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dsync
            dwrd_sync u_sync_d (
                .clk(CLK), .rst_n(rst_core_n), .ce(CE),
                .d(HOST_DATA[gi]), .q(data_q[gi])
            );
        end
    endgenerate

    logic wr_act;
    logic wr_take;
    assign wr_act = !wr_n_s && !cs_n_s;
    // A byte is taken once, on the rising edge of the write strobe
    assign wr_take = st_ff.wr_d && !wr_act;

    logic [7:0] masked_x;
    logic [7:0] masked_m;
    logic hit;
    assign masked_x = XFER_DATA & ~st_ff.mask;
    assign masked_m = st_ff.match_val & ~st_ff.mask;
    assign hit = XFER_DATA_VALID && (masked_x == masked_m)
                 && (st_ff.op_class[1] || st_ff.op_class == CLASS_SEARCH);

    // Next-state logic: byte classification, related-byte sequencing, events
    always_comb begin
        logic [7:0] d;
        logic [SLOT_N-1:0] p;
        logic [1:0] cause;
        d = data_q;
        p = st_ff.pend;
        cause = CAUSE_READY;
        nxt_st = st_ff;
        nxt_st.wr_d = wr_act;
        nxt_st.rp_wr = 1'b0;
        nxt_st.cmd_valid = 1'b0;
        nxt_st.match_hit = hit;
        nxt_st.match_stop = hit && st_ff.stop_match;
        nxt_st.pulse = BYTE_COUNT[7:0] == st_ff.pulse_off
                       && st_ff.int_ctl[B_P2] && XFER_DATA_VALID;
        // Zero length runs 2^16+1 bytes; pipelined read adds one more
        nxt_st.bytes_to_do = (st_ff.length == WORD_ZERO) ? LEN_ZERO_COUNT
            : 17'({1'b0, st_ff.length} + LEN_ADD);
        if (wr_take) begin
            case (st_ff.seq)
                SEQ_BASIC: begin
                    if (!d[B_TOP] && d[B_P1:B_P0] != TWO_ZERO) begin
                        nxt_st.op_class = d[B_P1:B_P0];
                        nxt_st.src_a = d[B_P2];
                        p = {1'b0, d[B_P6:B_P3]};
                        nxt_st.seq = SEQ_XFER;
                    end else if (!d[B_TOP] && d[B_P2]) begin
                        nxt_st.a_setup = d[B_P5:B_P3];
                        nxt_st.a_var = d[B_P6];
                        p = {4'h0, d[B_P6]};
                        nxt_st.seq = SEQ_PORTA;
                    end else if (!d[B_TOP]) begin
                        nxt_st.b_setup = d[B_P5:B_P3];
                        nxt_st.b_var = d[B_P6];
                        p = {4'h0, d[B_P6]};
                        nxt_st.seq = SEQ_PORTB;
                    end else if (d[B_P1:B_P0] == TWO_ZERO) begin
                        nxt_st.stop_match = d[B_P2];
                        nxt_st.int_en = d[B_P5];
                        nxt_st.bus_en = d[B_P6];
                        p = {3'h0, d[B_P4:B_P3]};
                        nxt_st.seq = SEQ_MATCH;
                    end else if (d[B_P0] && !d[B_P1]) begin
                        nxt_st.op_mode = d[B_P6:B_P5];
                        p = {2'h0, d[B_P4:B_P2]};
                        nxt_st.seq = SEQ_MODE;
                    end else if (!d[B_P0] && !d[B_P2] && !d[B_P6]) begin
                        nxt_st.rp_wr = 1'b1;
                        nxt_st.rp_byte = d;
                        p = SLOTS_NONE;
                    end else begin
                        nxt_st.cmd_valid = 1'b1;
                        nxt_st.cmd_byte = d;
                        p = SLOTS_NONE;
                    end
                end
                SEQ_XFER: begin
                    // Lowest pending slot takes the byte first
                    if (p[0]) begin
                        nxt_st.a_start[7:0] = d;
                        p[0] = 1'b0;
                    end else if (p[1]) begin
                        nxt_st.a_start[15:8] = d;
                        p[1] = 1'b0;
                    end else if (p[2]) begin
                        nxt_st.length[7:0] = d;
                        p[2] = 1'b0;
                    end else begin
                        nxt_st.length[15:8] = d;
                        p[3] = 1'b0;
                    end
                end
                SEQ_PORTA: begin
                    nxt_st.a_timing = d;
                    p = SLOTS_NONE;
                end
                SEQ_PORTB: begin
                    nxt_st.b_timing = d;
                    p = SLOTS_NONE;
                end
                SEQ_MATCH: begin
                    if (p[0]) begin
                        nxt_st.mask = d;
                        p[0] = 1'b0;
                    end else begin
                        nxt_st.match_val = d;
                        p[1] = 1'b0;
                    end
                end
                SEQ_MODE: begin
                    if (p[0]) begin
                        nxt_st.b_start[7:0] = d;
                        p[0] = 1'b0;
                    end else if (p[1]) begin
                        nxt_st.b_start[15:8] = d;
                        p[1] = 1'b0;
                    end else begin
                        nxt_st.int_ctl = d;
                        // Nested pointers replace the finished slot
                        p = {3'h0, d[B_P4:B_P3]};
                        nxt_st.seq = SEQ_INTCTL;
                    end
                end
                SEQ_INTCTL: begin
                    if (p[0]) begin
                        nxt_st.pulse_off = d;
                        p[0] = 1'b0;
                    end else begin
                        nxt_st.vector = d;
                        p[1] = 1'b0;
                    end
                end
                default: begin
                    p = SLOTS_NONE;
                end
            endcase
            nxt_st.pend = p;
            if (p == SLOTS_NONE) begin
                nxt_st.seq = SEQ_BASIC;
            end
        end
        // Sticky match flag until a new match control byte is programmed
        if (hit && !st_ff.stop_match) begin
            nxt_st.match_flag = 1'b1;
        end
        // Interrupt request: causes gated by the master enable
        if (hit && st_ff.int_ctl[B_P0]) begin
            cause = CAUSE_MATCH;
        end else if (BLOCK_END && st_ff.int_ctl[B_P1]) begin
            cause = CAUSE_END;
        end
        if (st_ff.int_en && ((hit && st_ff.int_ctl[B_P0])
                || (BLOCK_END && st_ff.int_ctl[B_P1])
                || (READY_SEEN && st_ff.int_ctl[B_P6]))) begin
            nxt_st.int_req = 1'b1;
            nxt_st.vec_out = st_ff.vector;
            if (st_ff.int_ctl[B_P5]) begin
                nxt_st.vec_out[B_P2:B_P1] = cause;
            end
        end else if (REENABLE) begin
            nxt_st.int_req = 1'b0;
        end
        if (wr_take && st_ff.seq == SEQ_BASIC && d[B_TOP]
                && d[B_P1:B_P0] == TWO_ZERO) begin
            nxt_st.match_flag = hit && !st_ff.stop_match;
        end
    end

    // All state registered at once; frozen while the clock enable is low
    always_ff @(posedge CLK or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_ff <= ST_RESET;
        end else if (CE) begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state flops
    assign OP_CLASS = st_ff.op_class;
    assign SRC_IS_A = st_ff.src_a;
    assign PORT_A_START = st_ff.a_start;
    assign PORT_B_START = st_ff.b_start;
    assign BYTES_TO_DO = st_ff.bytes_to_do;
    assign PORT_A_IS_IO = st_ff.a_setup[0];
    assign PORT_B_IS_IO = st_ff.b_setup[0];
    assign PORT_A_ADDR_MODE = st_ff.a_setup[2:1];
    assign PORT_B_ADDR_MODE = st_ff.b_setup[2:1];
    assign PORT_A_VAR_TIMING = st_ff.a_var;
    assign PORT_B_VAR_TIMING = st_ff.b_var;
    assign PORT_A_TIMING = st_ff.a_timing;
    assign PORT_B_TIMING = st_ff.b_timing;
    assign OP_MODE = st_ff.op_mode;
    assign BUS_ENABLE = st_ff.bus_en;
    assign STOP_ON_MATCH = st_ff.stop_match;
    assign MATCH_HIT = st_ff.match_hit;
    assign MATCH_STOP = st_ff.match_stop;
    assign MATCH_FLAG = st_ff.match_flag;
    assign INT_REQ = st_ff.int_req;
    assign PULSE_OUT = st_ff.pulse;
    assign INT_VECTOR = st_ff.vec_out;
    assign READY_POL_WR = st_ff.rp_wr;
    assign READY_POL_BYTE = st_ff.rp_byte;
    assign CMD_VALID = st_ff.cmd_valid;
    assign CMD_BYTE = st_ff.cmd_byte;
endmodule // dwrd_decoder

//--- tb/dwrd_properties.sv
// Checker: port-level timing and decode relations of the register decoder.
// Assumes the single CLK domain; bound into every decoder instance.
`timescale 1ns/1ps
module dwrd_properties (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic HOST_WR_N,
    input wire logic XFER_DATA_VALID,
    input wire logic READY_SEEN,
    input wire logic BLOCK_END,
    input wire logic REENABLE,
    input wire logic [1:0] OP_CLASS,
    input wire logic [15:0] PORT_A_START,
    input wire logic STOP_ON_MATCH,
    input wire logic MATCH_HIT,
    input wire logic MATCH_STOP,
    input wire logic MATCH_FLAG,
    input wire logic INT_REQ,
    input wire logic PULSE_OUT,
    input wire logic READY_POL_WR,
    input wire logic [7:0] READY_POL_BYTE,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_BYTE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // A stored byte lands on the third edge after the strobe pin rises
    a_store_latency: assert property ($changed(PORT_A_START) |->
        $past(HOST_WR_N, 3) && !$past(HOST_WR_N, 4))
        else $error("port A start changed off the write latency");
    a_stop_needs_hit: assert property (MATCH_STOP |->
        MATCH_HIT && STOP_ON_MATCH) else $error("stop without armed hit");
    a_flag_no_stop: assert property ($rose(MATCH_FLAG) |->
        MATCH_HIT && !MATCH_STOP) else $error("flag rose on wrong event");
    a_hit_search: assert property (MATCH_HIT |->
        $past(XFER_DATA_VALID) && OP_CLASS[1]) else $error("stray hit");
    a_int_clear: assert property (REENABLE && !BLOCK_END &&
        !READY_SEEN && !XFER_DATA_VALID |=> !INT_REQ)
        else $error("request not cleared by re-enable");
    a_int_cause: assert property ($rose(INT_REQ) |->
        $past(BLOCK_END) || $past(READY_SEEN) || $past(XFER_DATA_VALID))
        else $error("interrupt without a cause");
    a_cmd_class: assert property (CMD_VALID |->
        CMD_BYTE[7] && CMD_BYTE[1]) else $error("command class wrong");
    a_rpol_class: assert property (READY_POL_WR |->
        (READY_POL_BYTE & 8'hC7) == 8'h82) else $error("ready group wrong");
    // Main scenarios reached
    cover property (MATCH_STOP);
    cover property ($rose(INT_REQ));
    cover property (PULSE_OUT);
endmodule // dwrd_properties

bind dwrd_decoder dwrd_properties chk_u (.CLK(CLK), .RST_N(RST_N),
    .HOST_WR_N(HOST_WR_N), .XFER_DATA_VALID(XFER_DATA_VALID),
    .READY_SEEN(READY_SEEN), .BLOCK_END(BLOCK_END), .REENABLE(REENABLE),
    .OP_CLASS(OP_CLASS), .PORT_A_START(PORT_A_START),
    .STOP_ON_MATCH(STOP_ON_MATCH), .MATCH_HIT(MATCH_HIT),
    .MATCH_STOP(MATCH_STOP), .MATCH_FLAG(MATCH_FLAG), .INT_REQ(INT_REQ),
    .PULSE_OUT(PULSE_OUT), .READY_POL_WR(READY_POL_WR),
    .READY_POL_BYTE(READY_POL_BYTE), .CMD_VALID(CMD_VALID),
    .CMD_BYTE(CMD_BYTE));

//--- tb/dwrd_host_model.sv
// Host model: writes control bytes through the chip-select write port.
// Assumes wr() is called from a process synchronous to clk.
`timescale 1ns/1ps
module dwrd_host_model (
    input wire logic clk,
    output logic wr_n = 1'b1,
    output logic cs_n = 1'b1,
    output logic [7:0] data = 8'hA5
);
    // Strobe low and high three clocks or more; data outlives the sync
    task automatic wr(input logic [7:0] d);
        @(posedge clk);
        #1 cs_n = 1'b0;
        data = d;
        wr_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 wr_n = 1'b1;
        repeat (5) @(posedge clk);
        // Released bus shows the inverse so no stale byte can pass
        #1 cs_n = 1'b1;
        data = ~d;
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule // dwrd_host_model

//--- tb/dwrd_decoder_bench.sv
// Bench: programs every write group through the host model and checks
// decoded fields and event outputs; assumes a 25 MHz CLK.
`timescale 1ns/1ps
module dwrd_decoder_bench;
    logic CLK = 1'b0;
    logic RST_N, CE, READY_SEEN, BLOCK_END, REENABLE, XFER_DATA_VALID;
    logic HOST_WR_N, HOST_CS_N, SRC_IS_A, PORT_A_IS_IO, PORT_B_IS_IO;
    logic PORT_A_VAR_TIMING, PORT_B_VAR_TIMING, BUS_ENABLE, STOP_ON_MATCH;
    logic MATCH_HIT, MATCH_STOP, MATCH_FLAG, INT_REQ, PULSE_OUT;
    logic READY_POL_WR, CMD_VALID;
    logic [1:0] OP_CLASS, PORT_A_ADDR_MODE, PORT_B_ADDR_MODE, OP_MODE;
    logic [7:0] HOST_DATA, XFER_DATA, PORT_A_TIMING, PORT_B_TIMING;
    logic [7:0] INT_VECTOR, READY_POL_BYTE, CMD_BYTE;
    logic [15:0] BYTE_COUNT, PORT_A_START, PORT_B_START;
    logic [16:0] BYTES_TO_DO;
    logic [3:0] seen;
    int err_count = 0;
    int compares = 0;
    // Byte stream: transfer, ports, command, ready, length, match, mode
    localparam logic [7:0] PROG [0:25] = '{8'h7D, 8'h34, 8'h12, 8'hFF,
        8'h00, 8'h7C, 8'hCD, 8'h50, 8'h0E, 8'h83, 8'h8A, 8'h62, 8'h00,
        8'h00, 8'hFC, 8'h0F, 8'hA0, 8'hBD, 8'h78, 8'h56, 8'h7F, 8'h10,
        8'h40, 8'hF8, 8'h00, 8'h5A};
    dwrd_decoder dut_u (.CLK(CLK), .RST_N(RST_N), .CE(CE),
        .HOST_WR_N(HOST_WR_N), .HOST_CS_N(HOST_CS_N),
        .HOST_DATA(HOST_DATA), .BYTE_COUNT(BYTE_COUNT),
        .XFER_DATA(XFER_DATA), .XFER_DATA_VALID(XFER_DATA_VALID),
        .READY_SEEN(READY_SEEN), .BLOCK_END(BLOCK_END),
        .REENABLE(REENABLE), .OP_CLASS(OP_CLASS), .SRC_IS_A(SRC_IS_A),
        .PORT_A_START(PORT_A_START), .PORT_B_START(PORT_B_START),
        .BYTES_TO_DO(BYTES_TO_DO), .PORT_A_ADDR_MODE(PORT_A_ADDR_MODE),
        .PORT_B_ADDR_MODE(PORT_B_ADDR_MODE), .PORT_A_IS_IO(PORT_A_IS_IO),
        .PORT_B_IS_IO(PORT_B_IS_IO), .PORT_A_VAR_TIMING(PORT_A_VAR_TIMING),
        .PORT_B_VAR_TIMING(PORT_B_VAR_TIMING),
        .PORT_A_TIMING(PORT_A_TIMING), .PORT_B_TIMING(PORT_B_TIMING),
        .OP_MODE(OP_MODE), .BUS_ENABLE(BUS_ENABLE),
        .STOP_ON_MATCH(STOP_ON_MATCH), .MATCH_HIT(MATCH_HIT),
        .MATCH_STOP(MATCH_STOP), .MATCH_FLAG(MATCH_FLAG),
        .INT_REQ(INT_REQ), .PULSE_OUT(PULSE_OUT), .INT_VECTOR(INT_VECTOR),
        .READY_POL_WR(READY_POL_WR), .READY_POL_BYTE(READY_POL_BYTE),
        .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE));
    dwrd_host_model host_u (.clk(CLK), .wr_n(HOST_WR_N), .cs_n(HOST_CS_N),
        .data(HOST_DATA));
    // 40 ns period
    always #20 CLK = ~CLK;
    task automatic chk(input string what, input logic [16:0] exp,
        input logic [16:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic prog(input int first, input int last);
        for (int i = first; i <= last; i++) begin
            host_u.wr(PROG[i]);
        end
    endtask
    // One-cycle event; seen collects hit, stop, pulse and flag over 3 edges
    task automatic pulse(input logic [3:0] m);
        @(posedge CLK);
        #1 {READY_SEEN, BLOCK_END, REENABLE, XFER_DATA_VALID} = m;
        seen = 4'h0;
        @(posedge CLK);
        #1 {READY_SEEN, BLOCK_END, REENABLE, XFER_DATA_VALID} = 4'h0;
        repeat (3) begin
            seen = seen | {MATCH_HIT, MATCH_STOP, PULSE_OUT, MATCH_FLAG};
            @(posedge CLK);
            #1;
        end
    endtask
    task automatic results();
        $display("Compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog: tests need under 1000 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        err_count++;
        results();
    end
    // Main sequence
    initial begin
        RST_N = 1'b0;
        CE = 1'b1;
        {READY_SEEN, BLOCK_END, REENABLE, XFER_DATA_VALID} = 4'h0;
        BYTE_COUNT = 16'h0000;
        XFER_DATA = 8'hA5;
        repeat (3) @(posedge CLK);
        #1 RST_N = 1'b1;
        repeat (6) @(posedge CLK);
        chk("len", 17'h10001, BYTES_TO_DO);
        prog(0, 4);
        chk("class", 2'h1, OP_CLASS);
        chk("src", 1'b1, SRC_IS_A);
        chk("a_start", 16'h1234, PORT_A_START);
        chk("len", 17'h00100, BYTES_TO_DO);
        prog(5, 8);
        chk("a_io", 1'b1, PORT_A_IS_IO);
        chk("a_mode", 2'h3, PORT_A_ADDR_MODE);
        chk("a_var", 1'b1, PORT_A_VAR_TIMING);
        chk("a_tim", 8'hCD, PORT_A_TIMING);
        chk("b_mode", 2'h1, PORT_B_ADDR_MODE);
        chk("b_tim", 8'h0E, PORT_B_TIMING);
        chk("b_io", 1'b0, PORT_B_IS_IO);
        chk("b_var", 1'b1, PORT_B_VAR_TIMING);
        prog(9, 13);
        chk("cmd", 8'h83, CMD_BYTE);
        chk("rdy", 8'h8A, READY_POL_BYTE);
        chk("len", 17'h10001, BYTES_TO_DO);
        chk("class", 2'h2, OP_CLASS);
        prog(14, 22);
        chk("bus_en", 1'b1, BUS_ENABLE);
        chk("b_start", 16'h5678, PORT_B_START);
        chk("mode", 2'h1, OP_MODE);
        chk("stop_en", 1'b1, STOP_ON_MATCH);
        pulse(4'h1);
        chk("stop", 4'hC, seen);
        chk("vec", 8'h42, INT_VECTOR);
        pulse(4'h2);
        chk("int", 1'b0, INT_REQ);
        pulse(4'h8);
        chk("int", 1'b1, INT_REQ);
        chk("vec", 8'h40, INT_VECTOR);
        XFER_DATA = 8'hB5;
        pulse(4'h4);
        chk("int", 1'b1, INT_REQ);
        chk("vec", 8'h44, INT_VECTOR);
        BYTE_COUNT = 16'h0210;
        pulse(4'h1);
        chk("pulse", 4'h2, seen);
        prog(23, 25);
        chk("stop_en", 1'b0, STOP_ON_MATCH);
        XFER_DATA = 8'h5A;
        pulse(4'h1);
        chk("flag", 4'hB, seen);
        XFER_DATA = 8'h5B;
        pulse(4'h1);
        chk("miss", 4'h3, seen);
        results();
    end
endmodule // dwrd_decoder_bench
